// file: include/ifd_pkg.sv
// Field layout, codes and carrier structs for the instruction field decoder
package ifd_pkg;
    localparam int unsigned WORD_W = 32;
    localparam int unsigned REG_W = 5;
    localparam int unsigned IMM_W = 13;
    localparam int unsigned FUNC_W = 9;
    localparam int unsigned FMT_HI = 31;
    localparam int unsigned FMT_LO = 30;
    localparam int unsigned DST_HI = 29;
    localparam int unsigned DST_LO = 25;
    localparam int unsigned F2_HI = 24;
    localparam int unsigned F2_LO = 22;
    localparam int unsigned F3_HI = 24;
    localparam int unsigned F3_LO = 19;
    localparam int unsigned S1_HI = 18;
    localparam int unsigned S1_LO = 14;
    localparam int unsigned IMM_SEL_BIT = 13;
    localparam int unsigned FUNC_HI = 13;
    localparam int unsigned FUNC_LO = 5;
    localparam int unsigned ASI_HI = 12;
    localparam int unsigned ASI_LO = 5;
    localparam int unsigned S2_HI = 4;
    localparam int unsigned S2_LO = 0;

    localparam logic [1:0] FMT_BRANCH = 2'h0;
    localparam logic [1:0] FMT_CALL = 2'h1;
    localparam logic [1:0] FMT_ARITH = 2'h2;
    localparam logic [1:0] FMT_MEM = 2'h3;

    localparam logic [2:0] F2_UNIMP = 3'h0;
    localparam logic [2:0] F2_INT_BRANCH = 3'h2;
    localparam logic [2:0] F2_SET_UPPER = 3'h4;
    localparam logic [2:0] F2_FLOAT_BRANCH = 3'h6;
    localparam logic [2:0] F2_CP_BRANCH = 3'h7;

    // Format-3 selectors that carry their own function field
    localparam logic [5:0] F3_FLOAT_ARITH_A = 6'h34;
    localparam logic [5:0] F3_FLOAT_ARITH_B = 6'h35;
    localparam logic [5:0] F3_CP_ARITH_A = 6'h36;
    localparam logic [5:0] F3_CP_ARITH_B = 6'h37;
    localparam logic [REG_W-1:0] REG_ZERO = 5'h00;

    typedef enum logic [3:0] {
        CLS_NONE,
        CLS_UNIMP,
        CLS_INT_BRANCH,
        CLS_SET_UPPER,
        CLS_FLOAT_BRANCH,
        CLS_CP_BRANCH,
        CLS_CALL,
        CLS_ARITH,
        CLS_FLOAT_ARITH,
        CLS_CP_ARITH,
        CLS_MEM
    } class_e;

    typedef struct packed {
        logic valid;
        class_e cls;
        logic [1:0] format_code;
        logic [2:0] format2_selector;
        logic [5:0] format3_selector;
        logic [REG_W-1:0] dst_field;
        logic dst_is_src;
        logic dst_write;
        logic dst_float;
        logic [REG_W-1:0] first_src_field;
        logic [REG_W-1:0] second_src_field;
        logic src_float;
        logic first_src_zero;
        logic second_src_zero;
        logic use_imm;
        logic [WORD_W-1:0] short_signed_imm;
        logic [FUNC_W-1:0] func_field;
        logic illegal_trap;
        logic fp_exception;
        logic cp_exception;
    } decoded_s;
endpackage

// file: verilog/ifd_f3_table.sv
// Format-3 selector table: legality and operand roles
`timescale 1ns/1ns
module ifd_f3_table
(
    input wire logic [1:0] format_code,
    input wire logic [5:0] format3_selector,
    output logic legal,
    output logic is_store,
    output logic is_float,
    output logic uses_second
);
    // Arithmetic group (format 2): codes with no assigned operation
    function automatic logic arith_legal(input logic [5:0] s);
        arith_legal = !(s == 6'h09 || s == 6'h0d || (s >= 6'h2d && s <= 6'h2f)
            || s >= 6'h3e);
    endfunction

    // Memory group (format 3): loads, stores, swaps, float and cp transfers
    function automatic logic mem_legal(input logic [5:0] s);
        mem_legal = !(s == 6'h08 || s == 6'h0b || s == 6'h0c || s == 6'h0e
            || s == 6'h18 || s == 6'h1b || s == 6'h1c || s == 6'h1e
            || (s >= 6'h28 && s <= 6'h2f) || s == 6'h22 || s == 6'h26
            || s >= 6'h3c);
    endfunction

    always_comb
    begin
        if (format_code == ifd_pkg::FMT_MEM)
        begin
            legal = mem_legal(format3_selector);
            is_store = format3_selector[2] && !(format3_selector[3:0] == 4'hd
                || format3_selector[3:0] == 4'hf);
            is_float = format3_selector[5:4] == 2'h2;
        end
        else
        begin
            legal = arith_legal(format3_selector);
            is_store = 1'b0;
            is_float = format3_selector == ifd_pkg::F3_FLOAT_ARITH_A
                || format3_selector == ifd_pkg::F3_FLOAT_ARITH_B;
        end
        uses_second = 1'b1;
    end
endmodule

// file: verilog/instr_field_decoder.sv
// Registered field decoder for 32-bit integer-unit instruction words
`timescale 1ns/1ns
module instr_field_decoder
#(
    // Sizes are tied to the word layout; kept open only so a mismatch is refused
    parameter int unsigned IMM_BITS = ifd_pkg::IMM_W,
    parameter int unsigned FUNC_BITS = ifd_pkg::FUNC_W
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic instr_valid,
    input wire logic [ifd_pkg::WORD_W-1:0] instr_word,
    output ifd_pkg::decoded_s dec
);
    // All decode state, registered as one word
    typedef struct packed {
        ifd_pkg::decoded_s dec;
    } state_s;

    state_s state_r;
    state_s state_nxt;
    logic f3_legal;
    logic f3_store;
    logic f3_float;
    logic f3_second;

    // Decode is hard-wired to one word layout; refuse any other sizing
    if (IMM_BITS != ifd_pkg::IMM_W || IMM_BITS != ifd_pkg::IMM_SEL_BIT)
    begin : g_imm_check
        $error("immediate width does not fit the word layout");
    end
    if (FUNC_BITS != ifd_pkg::FUNC_HI - ifd_pkg::FUNC_LO + 1)
    begin : g_func_check
        $error("function field width does not fit the word layout");
    end
    // Field order matters to every slice below
    if (ifd_pkg::DST_LO != ifd_pkg::F3_HI + 1 || ifd_pkg::F3_LO != ifd_pkg::S1_HI + 1
        || ifd_pkg::S1_LO != ifd_pkg::IMM_SEL_BIT + 1)
    begin : g_layout_check
        $error("register fields do not tile the word");
    end

    // Integer register zero reads as zero and swallows writes
    function automatic logic is_reg_zero(input logic [ifd_pkg::REG_W-1:0] r);
        is_reg_zero = r == ifd_pkg::REG_ZERO;
    endfunction

    function automatic logic [ifd_pkg::REG_W-1:0] src2_of(input logic [ifd_pkg::WORD_W-1:0] w);
        src2_of = w[ifd_pkg::S2_HI:ifd_pkg::S2_LO];
    endfunction

    function automatic logic [ifd_pkg::WORD_W-1:0] sext_imm(
        input logic [ifd_pkg::WORD_W-1:0] w);
        sext_imm = {{(ifd_pkg::WORD_W-IMM_BITS){w[IMM_BITS-1]}}, w[IMM_BITS-1:0]};
    endfunction

    // Selectors whose low bits carry a function field instead of the select bit
    function automatic logic is_float_sel(input logic [5:0] s);
        is_float_sel = s == ifd_pkg::F3_FLOAT_ARITH_A || s == ifd_pkg::F3_FLOAT_ARITH_B;
    endfunction

    function automatic logic is_cp_sel(input logic [5:0] s);
        is_cp_sel = s == ifd_pkg::F3_CP_ARITH_A || s == ifd_pkg::F3_CP_ARITH_B;
    endfunction

    // Float function codes that are assigned; others raise an fp exception
    function automatic logic float_func_legal(input logic [8:0] f, input logic cmp);
        if (cmp)
            float_func_legal = f >= 9'h051 && f <= 9'h057;
        else
            float_func_legal = f == 9'h001 || f == 9'h005 || f == 9'h009
                || (f >= 9'h029 && f <= 9'h02b) || (f >= 9'h041 && f <= 9'h04f)
                || (f >= 9'h0c4 && f <= 9'h0cf && f[1:0] != 2'h0)
                || (f >= 9'h0d1 && f <= 9'h0d3);
    endfunction

    // Per-selector legality and operand roles live in the table
    ifd_f3_table u_f3_table
    (
        .format_code(instr_word[ifd_pkg::FMT_HI:ifd_pkg::FMT_LO]),
        .format3_selector(instr_word[ifd_pkg::F3_HI:ifd_pkg::F3_LO]),
        .legal(f3_legal),
        .is_store(f3_store),
        .is_float(f3_float),
        .uses_second(f3_second)
    );

    always_comb
    begin
        logic [1:0] fmt;
        logic [2:0] f2;
        logic [5:0] f3;
        logic [ifd_pkg::FUNC_W-1:0] fn;
        logic imm_sel;
        ifd_pkg::decoded_s d;
        fmt = instr_word[ifd_pkg::FMT_HI:ifd_pkg::FMT_LO];
        f2 = instr_word[ifd_pkg::F2_HI:ifd_pkg::F2_LO];
        f3 = instr_word[ifd_pkg::F3_HI:ifd_pkg::F3_LO];
        fn = instr_word[ifd_pkg::FUNC_HI:ifd_pkg::FUNC_LO];
        imm_sel = instr_word[ifd_pkg::IMM_SEL_BIT];
        d = '0;
        d.valid = instr_valid;
        d.cls = ifd_pkg::CLS_NONE;
        d.format_code = fmt;
        d.dst_field = instr_word[ifd_pkg::DST_HI:ifd_pkg::DST_LO];
        // Fields a format leaves unused keep the zero default
        case (fmt)
            ifd_pkg::FMT_BRANCH:
            begin
                d.format2_selector = f2;
                case (f2)
                    ifd_pkg::F2_UNIMP:
                    begin
                        d.cls = ifd_pkg::CLS_UNIMP;
                        d.illegal_trap = 1'b1;
                    end
                    ifd_pkg::F2_INT_BRANCH: d.cls = ifd_pkg::CLS_INT_BRANCH;
                    ifd_pkg::F2_SET_UPPER:
                    begin
                        d.cls = ifd_pkg::CLS_SET_UPPER;
                        d.dst_write = 1'b1;
                    end
                    ifd_pkg::F2_FLOAT_BRANCH: d.cls = ifd_pkg::CLS_FLOAT_BRANCH;
                    ifd_pkg::F2_CP_BRANCH: d.cls = ifd_pkg::CLS_CP_BRANCH;
                    default: d.illegal_trap = 1'b1;
                endcase
                // Branches use no register, immediate or function fields
                d.dst_field = (f2 == ifd_pkg::F2_SET_UPPER) ? d.dst_field
                    : ifd_pkg::REG_ZERO;
            end
            ifd_pkg::FMT_CALL:
            begin
                // Call marks no register write and clears the destination; displacement bits are not checked
                d.cls = ifd_pkg::CLS_CALL;
                d.dst_field = ifd_pkg::REG_ZERO;
            end
            default:
            begin
                d.format3_selector = f3;
                d.first_src_field = instr_word[ifd_pkg::S1_HI:ifd_pkg::S1_LO];
                d.dst_is_src = f3_store;
                d.dst_write = !f3_store;
                // Float loads and stores still form their address from integer registers
                d.src_float = f3_float && fmt != ifd_pkg::FMT_MEM;
                d.dst_float = f3_float;
                d.illegal_trap = !f3_legal;
                if (fmt == ifd_pkg::FMT_MEM)
                    d.cls = ifd_pkg::CLS_MEM;
                else if (is_float_sel(f3))
                    d.cls = ifd_pkg::CLS_FLOAT_ARITH;
                else if (is_cp_sel(f3))
                    d.cls = ifd_pkg::CLS_CP_ARITH;
                else
                    d.cls = ifd_pkg::CLS_ARITH;
                if (d.cls == ifd_pkg::CLS_FLOAT_ARITH)
                begin
                    // Function field replaces the select bit here
                    d.func_field = fn;
                    d.second_src_field = src2_of(instr_word);
                    d.fp_exception = !float_func_legal(fn,
                        f3 == ifd_pkg::F3_FLOAT_ARITH_B);
                end
                else if (d.cls == ifd_pkg::CLS_CP_ARITH)
                begin
                    // Coprocessor codes are defined by the attached unit
                    d.func_field = fn;
                    d.second_src_field = src2_of(instr_word);
                    d.cp_exception = 1'b0;
                end
                else if (imm_sel && f3_second)
                begin
                    // Register field under the immediate is dropped, not decoded
                    d.use_imm = 1'b1;
                    d.short_signed_imm = sext_imm(instr_word);
                end
                else
                begin
                    d.second_src_field = src2_of(instr_word);
                end
            end
        endcase
        if (!d.src_float)
        begin
            d.first_src_zero = is_reg_zero(d.first_src_field);
            d.second_src_zero = !d.use_imm && is_reg_zero(d.second_src_field);
        end
        if (!d.dst_float && is_reg_zero(d.dst_field))
            d.dst_write = 1'b0;
        // An idle cycle must never look like a trap
        if (!instr_valid)
        begin
            d.illegal_trap = 1'b0;
            d.fp_exception = 1'b0;
            d.cp_exception = 1'b0;
        end
        state_nxt.dec = d;
    end

    // Whole decode registered so every output leaves a flop
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            state_r <= '0;
        else
            state_r <= state_nxt;
    end

    // Output taken straight from the register
    assign dec = state_r.dec;
endmodule

// file: verif/ifd_props.sv
// Port checks for the instruction field decoder
`timescale 1ns/1ns
module ifd_props
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic instr_valid,
    input wire logic [ifd_pkg::WORD_W-1:0] instr_word,
    input wire ifd_pkg::decoded_s dec
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    wire logic [1:0] fm = instr_word[31:30];
    wire logic [5:0] f3 = instr_word[24:19];
    wire logic go = instr_valid;
    // Plain integer ops only: 00-07 are all legal
    wire logic alu = go && fm == 2'h2 && f3 < 6'h08;
    // Immediate words drop the second register field; float/cp ops keep it
    wire logic float_arith_instr = fm == 2'h2 && f3[5:2] == 4'hd;
    wire logic [4:0] s2_exp = (instr_word[13] && !float_arith_instr) ? 5'h00 : instr_word[4:0];
    idle_quiet_a: assert property (!go |=> !dec.valid && !dec.illegal_trap)
        else $error("decode raised without a word");
    call_fmt_a: assert property (go && fm == 2'h1 |=> dec.cls == ifd_pkg::CLS_CALL
        && !dec.illegal_trap) else $error("call format misdecoded");
    int_branch_a: assert property (go && fm == 2'h0 && instr_word[24:22] == 3'h2
        |=> dec.cls == ifd_pkg::CLS_INT_BRANCH) else $error("branch class wrong");
    f2_reserved_a: assert property (go && fm == 2'h0 && instr_word[22]
        && instr_word[24:23] != 2'h3 |=> dec.illegal_trap) else $error("no trap");
    f3_select_a: assert property (go && fm[1] |=> dec.format3_selector
        == $past(f3)) else $error("selector not passed");
    imm_extend_a: assert property (alu && instr_word[13] |=> dec.use_imm
        && dec.short_signed_imm == $past({{19{instr_word[12]}}, instr_word[12:0]}))
        else $error("immediate wrong");
    zero_dst_a: assert property (alu && instr_word[29:25] == 5'h00 |=> !dec.dst_write)
        else $error("write to register zero");
    src_fields_a: assert property (go && fm[1] |=> dec.first_src_field
        == $past(instr_word[18:14]) && dec.second_src_field == $past(s2_exp))
        else $error("source fields wrong");
    fp_func_a: assert property (go && fm == 2'h2 && f3[5:1] == 5'h1a
        |=> !dec.illegal_trap && dec.func_field == $past(instr_word[13:5]))
        else $error("function field wrong");
    store_role_a: assert property (go && fm == 2'h3 && f3 == 6'h04
        |=> dec.dst_is_src && !dec.dst_write) else $error("store role wrong");
    cover property (go && fm == 2'h1);
    cover property (dec.illegal_trap);
    cover property (dec.fp_exception);
endmodule
bind instr_field_decoder ifd_props u_props (.clk(clk), .rst_n(rst_n),
    .instr_valid(instr_valid), .instr_word(instr_word), .dec(dec));

// file: verif/fetch_model.sv
// Fetch stage model presenting words to the decoder
`timescale 1ns/1ns
module fetch_model
(
    input wire logic clk,
    input wire logic req_valid,
    input wire logic [31:0] req_word,
    output logic instr_valid,
    output logic [31:0] instr_word
);
    initial
    begin
        instr_valid = 1'b0;
        instr_word = 32'h0;
    end
    // Idle word flips each cycle so stale data is never mistaken
    always @(negedge clk)
    begin
        instr_valid <= req_valid;
        instr_word <= req_valid ? req_word : ~instr_word;
    end
endmodule

// file: verif/instr_field_decoder_tb_top.sv
// Testbench for the instruction field decoder
`timescale 1ns/1ns
module instr_field_decoder_tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic rq_v = 1'b0;
    logic [31:0] rq_w = 32'h0;
    logic instr_valid;
    logic [31:0] instr_word;
    ifd_pkg::decoded_s dec;
    int error_cnt = 0;
    int compares = 0;
    int cycles = 0;
    always #50 clk = ~clk;
    fetch_model partner (.clk(clk), .req_valid(rq_v), .req_word(rq_w),
        .instr_valid(instr_valid), .instr_word(instr_word));
    instr_field_decoder uut (.clk(clk), .rst_n(rst_n), .instr_valid(instr_valid),
        .instr_word(instr_word), .dec(dec));
    task automatic complete_run();
        if (error_cnt == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            error_cnt++;
            complete_run();
        end
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    function automatic logic [31:0] w3(input logic [1:0] f, input logic [4:0] rd,
        input logic [5:0] op, input logic [4:0] s1, input logic [13:0] lo);
        return {f, rd, op, s1, lo};
    endfunction
    // Entered and left at a falling edge; result stands after the second one
    task automatic run(input logic [31:0] w);
        rq_v = 1'b1;
        rq_w = w;
        @(negedge clk);
        @(negedge clk);
    endtask
    task automatic t_fmt2();
        ifd_pkg::class_e ec[8] = '{ifd_pkg::CLS_UNIMP, ifd_pkg::CLS_NONE,
            ifd_pkg::CLS_INT_BRANCH, ifd_pkg::CLS_NONE, ifd_pkg::CLS_SET_UPPER,
            ifd_pkg::CLS_NONE, ifd_pkg::CLS_FLOAT_BRANCH, ifd_pkg::CLS_CP_BRANCH};
        for (int s = 0; s < 8; s++)
        begin
            run({2'h0, 5'h1f, 3'(s), 22'h3fffff});
            chk("trap", {31'h0, s inside {0, 1, 3, 5}}, {31'h0, dec.illegal_trap});
            chk("sel2", {29'h0, 3'(s)}, {29'h0, dec.format2_selector});
            if (ec[s] != ifd_pkg::CLS_NONE)
                chk("cls", {28'h0, ec[s]}, {28'h0, dec.cls});
        end
        run({2'h1, 30'h3fffffff});
        chk("cls", {28'h0, ifd_pkg::CLS_CALL}, {28'h0, dec.cls});
        chk("trap", 32'h0, {31'h0, dec.illegal_trap});
    endtask
    task automatic t_alu();
        run(w3(2'h2, 5'h03, 6'h00, 5'h00, {1'b1, 13'h1fff}));
        chk("cls", {28'h0, ifd_pkg::CLS_ARITH}, {28'h0, dec.cls});
        chk("valid", 32'h1, {31'h0, dec.valid});
        chk("fmt", 32'h2, {30'h0, dec.format_code});
        chk("imm", 32'hffffffff, dec.short_signed_imm);
        chk("s1zero", 32'h1, {31'h0, dec.first_src_zero});
        run(w3(2'h2, 5'h00, 6'h02, 5'h04, {1'b1, 13'h0fff}));
        chk("imm", 32'h00000fff, dec.short_signed_imm);
        chk("dwr", 32'h0, {31'h0, dec.dst_write});
        chk("s1", 32'h4, {27'h0, dec.first_src_field});
        run(w3(2'h2, 5'h01, 6'h00, 5'h02, {1'b0, 8'hff, 5'h07}));
        chk("useimm", 32'h0, {31'h0, dec.use_imm});
        chk("s2", 32'h7, {27'h0, dec.second_src_field});
        chk("trap", 32'h0, {31'h0, dec.illegal_trap});
        chk("sel", 32'h0, {26'h0, dec.format3_selector});
    endtask
    task automatic t_mem();
        run(w3(2'h3, 5'h05, 6'h04, 5'h01, {1'b1, 13'h0010}));
        chk("cls", {28'h0, ifd_pkg::CLS_MEM}, {28'h0, dec.cls});
        chk("dsrc", 32'h1, {31'h0, dec.dst_is_src});
        chk("dwr", 32'h0, {31'h0, dec.dst_write});
        chk("dst", 32'h5, {27'h0, dec.dst_field});
        run(w3(2'h3, 5'h05, 6'h00, 5'h01, {1'b1, 13'h0010}));
        chk("dsrc", 32'h0, {31'h0, dec.dst_is_src});
        chk("dwr", 32'h1, {31'h0, dec.dst_write});
        // Float load: integer address registers, float destination zero is kept
        run(w3(2'h3, 5'h00, 6'h20, 5'h00, {1'b1, 13'h0008}));
        chk("sfl", 32'h0, {31'h0, dec.src_float});
        chk("s1zero", 32'h1, {31'h0, dec.first_src_zero});
        chk("dfl", 32'h1, {31'h0, dec.dst_float});
        chk("dwr", 32'h1, {31'h0, dec.dst_write});
    endtask
    task automatic t_bad();
        run(w3(2'h2, 5'h01, 6'h09, 5'h01, 14'h0));
        chk("trap", 32'h1, {31'h0, dec.illegal_trap});
        chk("s2zero", 32'h1, {31'h0, dec.second_src_zero});
        run(w3(2'h3, 5'h01, 6'h08, 5'h01, 14'h0));
        chk("trap", 32'h1, {31'h0, dec.illegal_trap});
        run(w3(2'h2, 5'h02, 6'h35, 5'h03, {9'h1ff, 5'h04}));
        chk("fpx", 32'h1, {31'h0, dec.fp_exception});
        chk("trap", 32'h0, {31'h0, dec.illegal_trap});
        run(w3(2'h2, 5'h02, 6'h35, 5'h03, {9'h051, 5'h04}));
        chk("fpx", 32'h0, {31'h0, dec.fp_exception});
        chk("sfl", 32'h1, {31'h0, dec.src_float});
        run(w3(2'h2, 5'h02, 6'h36, 5'h03, {9'h1ff, 5'h04}));
        chk("cls", {28'h0, ifd_pkg::CLS_CP_ARITH}, {28'h0, dec.cls});
        chk("cpx", 32'h0, {31'h0, dec.cp_exception});
        chk("trap", 32'h0, {31'h0, dec.illegal_trap});
        chk("func", 32'h1ff, {23'h0, dec.func_field});
        chk("s2", 32'h4, {27'h0, dec.second_src_field});
        rq_v = 1'b0;
        @(negedge clk);
        @(negedge clk);
        chk("valid", 32'h0, {31'h0, dec.valid});
    endtask
    initial
    begin
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        t_fmt2();
        t_alu();
        t_mem();
        t_bad();
        complete_run();
    end
endmodule
